// *** hdl/tps_pkg.sv ***
// Package for the 8-bit timer/counter with shared prescaler.
// Assumes one clock, one clk edge per instruction cycle.
package tps_pkg;

    // Register word offsets on the plain register port.
    localparam int           ADDR_W     = 4;
    localparam logic [3:0]   OFF_COUNT  = 4'h0;
    localparam logic [3:0]   OFF_CFG    = 4'h1;
    localparam logic [3:0]   OFF_STATUS = 4'h2;
    localparam logic [3:0]   OFF_MASK   = 4'h3;

    // Reset values.
    localparam logic [7:0]   CFG_RST    = 8'hff;
    localparam logic [7:0]   COUNT_RST  = 8'h00;
    localparam logic [7:0]   STATUS_RST = 8'h00;
    localparam logic [7:0]   MASK_RST   = 8'h00;

    // Status and mask field positions.
    localparam int           OVF_BIT    = 0;

    // Cycles with no increment after a count write.
    localparam logic [1:0]   INH_CYCLES = 2'h2;

    // Count value that wraps to zero.
    localparam logic [7:0]   COUNT_TOP  = 8'hff;

    // Configuration register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic       pullup_global_disable;
        logic       ext_int_edge_sel;
        logic       count_source_sel;
        logic       source_edge_sel;
        logic       prescaler_assign;
        logic [2:0] prescale_rate;
    } tps_cfg_t;

    // Prescaler count bits that must all be set for an output tick.
    // The timer gets 1:2 to 1:256, the watchdog 1:1 to 1:128.
    function automatic logic [7:0] tps_ps_mask(input logic [2:0] rate,
                                               input logic       to_wdt);
        logic [8:0] one;
        logic [8:0] m;
        one = 9'h001 << rate;
        if (!to_wdt) begin
            one = one << 1;
        end
        m = one - 9'h001;
        return m[7:0];
    endfunction : tps_ps_mask

endpackage : tps_pkg

// *** hdl/tps_edge.sv ***
// Synchroniser and edge detector for the external count input.
// Assumes the pin is slow against clk; one pulse per selected edge.
`timescale 1ns/1ns
`default_nettype none
module tps_edge
    import tps_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pin and edge choice, 1 selects falling
    input  wire logic pin,
    input  wire logic falling_sel,
    // One-cycle pulse per qualifying edge
    output logic      edge_pulse
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign edge_pulse = falling_sel ? (prev_q & ~sync2_q)
                                    : (~prev_q & sync2_q);

endmodule : tps_edge
`default_nettype wire

// *** hdl/tps_prescaler.sv ***
// Shared 8-bit prescaler, serving either the timer or the watchdog.
// Assumes the caller gates the input pulse and drives the clear.
`timescale 1ns/1ns
`default_nettype none
module tps_prescaler
    import tps_pkg::*;
#(
    parameter int W = 8
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         clr,
    input  wire logic         pulse,
    input  wire logic [2:0]   rate,
    input  wire logic         to_wdt,
    // Result
    output logic              tick,
    output logic [W-1:0]      cnt_q
);
    logic [W-1:0] mask;

    assign mask = W'(tps_ps_mask(rate, to_wdt));
    assign tick = pulse && ((cnt_q & mask) == mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (pulse) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

endmodule : tps_prescaler
`default_nettype wire

// *** hdl/tps_top.sv ***
// Timer/counter top: count, configuration, status and mask registers.
// Assumes one clk edge per instruction cycle and synchronous strobes.
//
// How it works
// - An 8-bit count register, readable and writable by software.
// - Source select 0: count once per instruction cycle, through the prescaler when it is assigned to the timer.
// - No increment in the two cycles that follow a count write.
// - Source select 1: count on active edges of the external input.
// - Edge select bit picks rising or falling external edges.
// - One 8-bit prescaler, given to timer or watchdog, never both.
// - Assignment bit 0 gives the prescaler to the timer, 1 to watchdog.
// - Timer side offers eight ratios 1:2 to 1:256 from the rate field.
// - Timer runs 1:1 only while the prescaler serves the watchdog.
// - Prescaler count is never readable or writable by software.
// - With prescaler on timer, a count write clears the prescaler.
// - With prescaler on watchdog, a watchdog clear clears it too.
// - Wrap from ff to 00 sets the overflow flag, enabled or not.
// - Edge select 1 counts falling edges, 0 counts rising edges.
// - Rate codes double: timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// - Timer frozen during sleep, so no overflow wakes the core.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tps_top
    import tps_pkg::*;
#(
    parameter int CW = 8
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [7:0]             rdata_q,
    // Core and watchdog side
    input  wire logic              sleep_mode,
    input  wire logic              watchdog_clear_instr,
    input  wire logic              wdt_base_pulse,
    output logic                   wdt_tick_q,
    // Pin
    input  wire logic              ext_count_input,
    // Interrupt and configuration outputs
    output logic                   irq_q,
    output logic                   pullup_global_disable_q,
    output logic                   ext_int_edge_sel_q
);

    // Registers.
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    tps_cfg_t      cfg_q;
    logic [7:0]    status_q;
    logic [7:0]    status_d;
    logic [7:0]    mask_q;
    logic [1:0]    inh_q;
    logic [1:0]    inh_d;
    logic [7:0]    rdata_d;
    logic          irq_d;
    logic          wdt_tick_d;

    // Decodes.
    logic          wr_count;
    logic          wr_cfg;
    logic          wr_mask;
    logic          rd_status;
    logic          to_wdt;
    logic          ext_pulse;
    logic          src_pulse;
    logic          ps_in;
    logic          ps_clr;
    logic          ps_tick;
    logic [7:0]    ps_cnt;
    logic          inc;
    logic          ovf;

    assign wr_count  = wr && (addr == OFF_COUNT);
    assign wr_cfg    = wr && (addr == OFF_CFG);
    assign wr_mask   = wr && (addr == OFF_MASK);
    assign rd_status = rd && (addr == OFF_STATUS);

    assign to_wdt    = cfg_q.prescaler_assign;

    // External edges are found on synchronised samples, ahead of the
    // prescaler, so each edge feeds one pulse into the count path.
    tps_edge u_edge (
        .clk         (clk),
        .rst_n       (rst_n),
        .pin         (ext_count_input),
        .falling_sel (cfg_q.source_edge_sel),
        .edge_pulse  (ext_pulse)
    );

    // Timer source: every instruction cycle or an external edge.
    // Sleep stops the source, so the timer cannot overflow then.
    assign src_pulse = !sleep_mode &&
                       (cfg_q.count_source_sel ? ext_pulse : 1'b1);

    // The prescaler sees the timer source or the watchdog base tick.
    assign ps_in  = to_wdt ? wdt_base_pulse : src_pulse;
    assign ps_clr = to_wdt ? watchdog_clear_instr : wr_count;

    // The prescaler count has no register address at all.
    tps_prescaler #(
        .W (8)
    ) u_ps (
        .clk    (clk),
        .rst_n  (rst_n),
        .clr    (ps_clr),
        .pulse  (ps_in),
        .rate   (cfg_q.prescale_rate),
        .to_wdt (to_wdt),
        .tick   (ps_tick),
        .cnt_q  (ps_cnt)
    );

    // With the prescaler away at the watchdog the timer runs 1:1.
    // A count write in the same cycle wins, so it can neither wrap nor flag.
    assign inc = !wr_count && (inh_q == 2'h0) &&
                 (to_wdt ? src_pulse : ps_tick);
    assign ovf = inc && (count_q == CW'(COUNT_TOP));

    // Next values.
    assign count_d = wr_count ? CW'(wdata)
                   : inc      ? count_q + CW'(1)
                   : count_q;
    assign inh_d   = wr_count        ? INH_CYCLES
                   : (inh_q != 2'h0) ? inh_q - 2'h1
                   : inh_q;

    // A read clears the status, but a same-cycle overflow wins.
    assign status_d = (rd_status ? 8'h00 : status_q) |
                      (8'(ovf) << OVF_BIT);

    assign rdata_d = !rd                  ? 8'h00
                   : addr == OFF_COUNT    ? 8'(count_q)
                   : addr == OFF_CFG      ? cfg_q
                   : addr == OFF_STATUS   ? status_q
                   : addr == OFF_MASK     ? mask_q
                   : 8'h00;

    assign irq_d      = |(status_d & mask_q);
    assign wdt_tick_d = to_wdt ? ps_tick : wdt_base_pulse;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= CW'(COUNT_RST);
            inh_q   <= 2'h0;
        end else begin
            count_q <= count_d;
            inh_q   <= inh_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q  <= tps_cfg_t'(CFG_RST);
            mask_q <= MASK_RST;
        end else begin
            if (wr_cfg) begin
                cfg_q <= tps_cfg_t'(wdata);
            end
            if (wr_mask) begin
                mask_q <= wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q   <= STATUS_RST;
            rdata_q    <= 8'h00;
            irq_q      <= 1'b0;
            wdt_tick_q <= 1'b0;
        end else begin
            status_q   <= status_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
            wdt_tick_q <= wdt_tick_d;
        end
    end

    assign pullup_global_disable_q = cfg_q.pullup_global_disable;
    assign ext_int_edge_sel_q      = cfg_q.ext_int_edge_sel;

    // Software sequences for moving the prescaler are the caller's
    // duty; the block only honours whichever clear matches the owner.

    // Checks.

    a_write_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_count |=> (count_q == $past(CW'(wdata))))
        else $error("count write not loaded");

    a_inhibit_two: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_count ##1 !wr_count ##1 !wr_count
        |=> (count_q == $past(count_q, 2)))
        else $error("count moved inside the write hold-off");

    a_timer_mode: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!cfg_q.count_source_sel && to_wdt && !sleep_mode &&
         inh_q == 2'h0 && !wr_count)
        |=> (count_q == $past(count_q) + CW'(1)))
        else $error("timer mode missed an instruction cycle");

    a_ext_edge: assert property (
        @(posedge clk) disable iff (!rst_n)
        (cfg_q.count_source_sel && !ext_pulse && !wr_count)
        |=> $stable(count_q))
        else $error("counter mode moved without an edge");

    a_edge_polarity: assert property (
        @(posedge clk) disable iff (!rst_n)
        ext_pulse |-> (cfg_q.source_edge_sel ? !u_edge.sync2_q
                                             : u_edge.sync2_q))
        else $error("edge pulse on the wrong transition");

    a_ps_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_count && !to_wdt) |=> (ps_cnt == 8'h00))
        else $error("count write left prescaler uncleared");

    a_wdt_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (watchdog_clear_instr && to_wdt) |=> (ps_cnt == 8'h00))
        else $error("watchdog clear left prescaler uncleared");

    a_ovf_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((count_q == CW'(COUNT_TOP) && !wr_count) ##1 count_q == CW'(0))
        |-> status_q[OVF_BIT])
        else $error("wrap did not set the overflow flag");

    a_sleep_freeze: assert property (
        @(posedge clk) disable iff (!rst_n)
        (sleep_mode && !wr_count) |=> $stable(count_q))
        else $error("timer moved during sleep");

    a_rate_div: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!to_wdt && cfg_q.prescale_rate == 3'h0 && ps_tick)
        |-> ps_cnt[0])
        else $error("1:2 ratio ticked on an even count");

    a_irq_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq_q == $past(|(status_d & mask_q)))
        else $error("interrupt output disagrees with status");

    // The checks below watch the register port, the hold-off, the flag, the prescaler, sleep and the pin edge.
    // They are cheap, so they stay beside the logic instead of in the bench.

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rd |=> (rdata_q == 8'h00))
        else $error("read data not zero outside a read");

    a_count_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd && addr == OFF_COUNT) |=> (rdata_q == $past(8'(count_q))))
        else $error("count read returned a stale value");

    a_unmapped_rd: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd && addr > OFF_MASK) |=> (rdata_q == 8'h00))
        else $error("unmapped read returned data");

    a_cfg_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_cfg |=> (8'(cfg_q) == $past(wdata)))
        else $error("configuration write not loaded");

    a_mask_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_mask |=> (mask_q == $past(wdata)))
        else $error("mask write not loaded");

    a_inh_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_count |=> (inh_q == INH_CYCLES))
        else $error("count write did not start the hold-off");

    a_inh_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (inh_q != 2'h0 && !wr_count) |=> $stable(count_q))
        else $error("count moved during the hold-off");

    a_status_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_status && !ovf) |=> !status_q[OVF_BIT])
        else $error("status read did not clear the flag");

    a_ovf_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        (status_q[OVF_BIT] && !rd_status) |=> status_q[OVF_BIT])
        else $error("overflow flag dropped without a read");

    a_ovf_cause: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!status_q[OVF_BIT] ##1 status_q[OVF_BIT])
        |-> (count_q == CW'(0) && $past(count_q) == CW'(COUNT_TOP)))
        else $error("overflow flag set without a wrap");

    a_irq_masked: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mask_q == 8'h00) |=> !irq_q)
        else $error("interrupt raised with every source masked");

    a_ps_wdt_owner: assert property (
        @(posedge clk) disable iff (!rst_n)
        (to_wdt && !wdt_base_pulse && !watchdog_clear_instr) |=> $stable(ps_cnt))
        else $error("watchdog prescaler moved on a timer pulse");

    a_ps_tmr_owner: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!to_wdt && !src_pulse && !wr_count) |=> $stable(ps_cnt))
        else $error("timer prescaler moved without a source pulse");

    a_wdt_bypass: assert property (
        @(posedge clk) disable iff (!rst_n)
        !to_wdt |=> (wdt_tick_q == $past(wdt_base_pulse)))
        else $error("watchdog divided while the timer owns the prescaler");

    a_wdt_unity: assert property (
        @(posedge clk) disable iff (!rst_n)
        (to_wdt && cfg_q.prescale_rate == 3'h0) |=> (wdt_tick_q == $past(wdt_base_pulse)))
        else $error("watchdog rate 0 is not 1:1");

    a_rate_top: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!to_wdt && cfg_q.prescale_rate == 3'h7 && ps_tick) |-> (ps_cnt == 8'hff))
        else $error("1:256 ratio ticked early");

    a_sleep_idle: assert property (
        @(posedge clk) disable iff (!rst_n)
        sleep_mode |-> !inc)
        else $error("increment issued during sleep");

    a_edge_single: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ext_pulse && !wr_cfg) |=> !ext_pulse)
        else $error("one pin edge gave two pulses");

endmodule : tps_top
`default_nettype wire

// *** verification/tps_pulse_src.sv ***
// Model of the pulse source that drives the external count pin.
// Assumes the bench calls send from its main process, one burst at a time.
`timescale 1ns/1ns
`default_nettype none
module tps_pulse_src (
    // Clock
    input  wire logic clk,
    // Pin
    output logic      pin
);
    initial pin = 1'b0;

    // Each level is held several clocks, since the pin is seen through a synchroniser.
    task automatic send(input int n, input int lo, input int hi);
        for (int i = 0; i < n; i++) begin
            repeat (lo) @(posedge clk);
            pin <= 1'b1;
            repeat (hi) @(posedge clk);
            pin <= 1'b0;
        end
    endtask : send
endmodule : tps_pulse_src
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the timer/counter with shared prescaler.
// Assumes tps_pulse_src drives the count pin; one clock at 100 MHz.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import tps_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0]        wdata = 8'h00;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              sleep_mode = 1'b0;
    logic              wd_clr = 1'b0;
    logic              base = 1'b0;
    logic [7:0]        rdata_q;
    logic              wdt_tick_q;
    logic              irq_q;
    logic              pud_q;
    logic              ied_q;
    logic              pin;
    logic [7:0]        v;
    logic [7:0]        w;
    logic [7:0]        x;
    int                errors = 0;
    int                comparisons = 0;
    int                cycles = 0;
    int                ticks = 0;
    int                seed = 40301;
    int                n;
    int                t0;

    tps_top uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                 .rdata_q(rdata_q), .sleep_mode(sleep_mode), .watchdog_clear_instr(wd_clr),
                 .wdt_base_pulse(base), .wdt_tick_q(wdt_tick_q), .ext_count_input(pin),
                 .irq_q(irq_q), .pullup_global_disable_q(pud_q), .ext_int_edge_sel_q(ied_q));
    tps_pulse_src src (.clk(clk), .pin(pin));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wdt_tick_q === 1'b1) begin
            ticks <= ticks + 1;
        end
        if (cycles == 20000) begin
            errors = errors + 1;
            finish_test();
        end
    end

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    task automatic check_n(input string name, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_n

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata_q;
    endtask : rd_reg

    task automatic wd_clear();
        @(posedge clk);
        wd_clr <= 1'b1;
        @(posedge clk);
        wd_clr <= 1'b0;
    endtask : wd_clear

    // A count write holds the count still for the two cycles after it.
    function automatic logic [7:0] exp_cnt(input logic [7:0] c, input int j);
        return 8'(int'(c) + ((j > 1) ? j - 1 : 0));
    endfunction : exp_cnt

    task automatic finish_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wr_reg(4'h5, 8'h5a);
        wr_reg(OFF_STATUS, 8'hff);
        for (int a = 0; a < 6; a++) begin
            rd_reg(a[ADDR_W-1:0], v);
            check8("reset value", (a == 1) ? CFG_RST : 8'h00, v);
        end
        wr_reg(OFF_CFG, 8'h08);
        for (int i = 0; i < 14; i++) begin
            x = (i == 0) ? 8'hff : 8'($random(seed));
            wr_reg(OFF_COUNT, x);
            repeat (i % 7) @(posedge clk);
            rd_reg(OFF_COUNT, v);
            check8("count after write", exp_cnt(x, i % 7), v);
        end
        wr_reg(OFF_COUNT, 8'h00);
        rd_reg(OFF_STATUS, v);
        wr_reg(OFF_MASK, 8'h01);
        wr_reg(OFF_COUNT, 8'hfe);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check8("irq before wrap", 8'h00, {7'h00, irq_q});
        repeat (4) @(posedge clk);
        @(negedge clk);
        check8("irq after wrap", 8'h01, {7'h00, irq_q});
        rd_reg(OFF_STATUS, v);
        check8("status", 8'h01, v);
        rd_reg(OFF_STATUS, v);
        check8("status cleared", 8'h00, v);
        check8("irq cleared", 8'h00, {7'h00, irq_q});
        wr_reg(OFF_MASK, 8'h00);
        repeat (300) @(posedge clk);
        @(negedge clk);
        check8("irq masked", 8'h00, {7'h00, irq_q});
        rd_reg(OFF_STATUS, v);
        check8("status masked", 8'h01, v);
        @(posedge clk);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(OFF_COUNT, w);
        repeat (20) @(posedge clk);
        rd_reg(OFF_COUNT, v);
        check8("count in sleep", w, v);
        @(posedge clk);
        sleep_mode <= 1'b0;
        for (int se = 0; se < 2; se++) begin
            wr_reg(OFF_CFG, {2'b00, 1'b1, se[0], 1'b1, 3'h0});
            repeat (6) @(posedge clk);
            x = 8'($random(seed));
            n = 1 + ($random(seed) & 7);
            wr_reg(OFF_COUNT, x);
            src.send(n, 3, 3);
            repeat (8) @(posedge clk);
            rd_reg(OFF_COUNT, v);
            check8("pin edges", 8'(int'(x) + n), v);
        end
        @(posedge clk);
        base <= 1'b1;
        for (int r = 0; r < 8; r++) begin
            for (int p = 0; p < 2; p++) begin
                wd_clear();
                x = {2'($random(seed)), 2'b00, p[0], r[2:0]};
                if (p == 1) begin
                    wr_reg(OFF_COUNT, 8'h00);
                    wr_reg(OFF_CFG, {x[7:3], 3'h0});
                    wd_clear();
                end
                wr_reg(OFF_CFG, x);
                @(negedge clk);
                check8("cfg pins", {6'h00, x[7:6]}, {6'h00, pud_q, ied_q});
                n = 4 << r;
                rd_reg(OFF_COUNT, w);
                t0 = ticks;
                repeat (n - 2) @(posedge clk);
                rd_reg(OFF_COUNT, v);
                check8("count step", (p == 1) ? 8'(n) : 8'h02, v - w);
                check_n("watchdog ticks", (p == 1) ? 4 : n, ticks - t0);
            end
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
